// ===== rtl/gain_switch_pkg.sv
// constants and carrier types shared by the gain switching logic
package gain_switch_pkg;

    // ----------------------------------------------------------------
    // widths and parameter slots
    // ----------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 6;
    localparam int DROOP_W = 32;
    localparam int NUM_PARAMS = 13;
    localparam int NUM_CORE = 4;
    localparam int IDX_INERTIA = 0;
    localparam int IDX_POSITION = 1;
    localparam int IDX_SPEED = 2;
    localparam int IDX_INTEGRAL = 3;
    localparam int IDX_MODEL = 4;
    localparam int IDX_VIB_FIRST = 5;

    // ----------------------------------------------------------------
    // register offsets (bank offsets take the slot index in the low bits)
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_SELECT = 6'h00;
    localparam logic [ADDR_W-1:0] REG_THRESHOLD = 6'h01;
    localparam logic [ADDR_W-1:0] REG_TC = 6'h02;
    localparam logic [ADDR_W-1:0] REG_STATUS = 6'h03;
    localparam logic [1:0] BANK_BASE = 2'h1;
    localparam logic [1:0] BANK_ALT = 2'h2;
    localparam logic [1:0] BANK_OUT = 2'h3;

    // ----------------------------------------------------------------
    // selection value fields
    // ----------------------------------------------------------------
    localparam int SEL_TRIG_LSB = 0;
    localparam int SEL_TCOPT_LSB = 8;
    localparam int SEL_FIELD_W = 4;

    typedef enum logic [3:0] {
        TRIG_NONE = 4'h0,
        TRIG_CMD = 4'h1,
        TRIG_DROOP = 4'h3
    } trigger_e;

    typedef enum logic [3:0] {
        TC_BOTH = 4'h0,
        TC_NO_SWITCH_LAG = 4'h1,
        TC_NO_RETURN_LAG = 4'h2
    } tc_option_e;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] SELECT_RST = 16'h0000;
    localparam logic [DATA_W-1:0] THRESHOLD_RST = 16'h0032;
    localparam logic [DATA_W-1:0] TC_RST = 16'h0064;
    localparam logic [DATA_W-1:0] PARAM_RST = 16'h0000;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CTRL_CYCLE_NS = 20000;
    localparam int CTRL_CYCLE_CLKS = CTRL_CYCLE_NS / CLK_PERIOD_NS;
    localparam int NS_PER_MS = 1000000;
    localparam int ALPHA_FRAC = 16;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef logic [NUM_PARAMS-1:0][DATA_W-1:0] param_vec_t;

    typedef struct packed {
        logic settling;
        logic active;
    } switch_status_s;

endpackage : gain_switch_pkg

// ===== rtl/lag_filter_channel.sv
// one first-order lag channel, stepped once per control cycle
`timescale 1ns/100ps
module lag_filter_channel #(
    parameter int WIDTH = 16,
    parameter int FRAC = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic bypass,
    input wire logic [FRAC:0] alpha,
    input wire logic [WIDTH-1:0] target,
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] next_value;
    logic signed [WIDTH:0] diff;
    logic signed [WIDTH+FRAC+2:0] prod;
    logic signed [WIDTH:0] step;

    always_comb begin
        diff = $signed({1'b0, target}) - $signed({1'b0, value});
        prod = diff * $signed({1'b0, alpha});
        step = (WIDTH+1)'(prod >>> FRAC);
        // truncation would otherwise stall the lag short of the target once the scaled step falls below one count
        if (step == '0 && diff != '0) begin
            step = diff[WIDTH] ? -(WIDTH+1)'(1) : (WIDTH+1)'(1);
        end
        next_value = value;
        if (tick) begin
            if (bypass) begin
                next_value = target;
            end else begin
                next_value = WIDTH'($signed({1'b0, value}) + step);
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            value <= '0;
        end else begin
            value <= next_value;
        end
    end

endmodule : lag_filter_channel

// ===== rtl/gain_switch_core.sv
// gain switching between base and alternate loop parameter sets
`timescale 1ns/100ps
module gain_switch_core #(
    parameter int CYCLE_CLKS = gain_switch_pkg::CTRL_CYCLE_CLKS,
    parameter int CYCLE_NS = gain_switch_pkg::CTRL_CYCLE_NS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [gain_switch_pkg::ADDR_W-1:0] addr,
    input wire logic [gain_switch_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [gain_switch_pkg::DATA_W-1:0] rdata,
    input wire logic ctrl_gain_switch_cmd,
    input wire logic gain_switch_input,
    input wire logic signed [gain_switch_pkg::DROOP_W-1:0] droop_pulses,
    output gain_switch_pkg::param_vec_t param_out,
    output gain_switch_pkg::switch_status_s status
);

    localparam int DW = gain_switch_pkg::DATA_W;
    localparam int NP = gain_switch_pkg::NUM_PARAMS;
    localparam int AF = gain_switch_pkg::ALPHA_FRAC;
    localparam int CNT_W = $clog2(CYCLE_CLKS + 1);
    localparam int DIV_W = 48;

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [DW-1:0] gain_switch_select, next_gain_switch_select;
    logic [DW-1:0] switch_droop_threshold, next_switch_droop_threshold;
    logic [DW-1:0] switch_time_constant, next_switch_time_constant;
    gain_switch_pkg::param_vec_t base_set, next_base_set;
    gain_switch_pkg::param_vec_t alt_set, next_alt_set;
    logic [DW-1:0] next_rdata;
    logic [1:0] bank;
    logic [3:0] slot;
    logic slot_ok;

    always_comb begin
        bank = addr[5:4];
        slot = addr[3:0];
        slot_ok = 32'(slot) < NP;
        next_gain_switch_select = gain_switch_select;
        next_switch_droop_threshold = switch_droop_threshold;
        next_switch_time_constant = switch_time_constant;
        next_base_set = base_set;
        next_alt_set = alt_set;
        next_rdata = '0;
        if (wr) begin
            if (addr == gain_switch_pkg::REG_SELECT) begin
                next_gain_switch_select = wdata;
            end else if (addr == gain_switch_pkg::REG_THRESHOLD) begin
                next_switch_droop_threshold = wdata;
            end else if (addr == gain_switch_pkg::REG_TC) begin
                next_switch_time_constant = wdata;
            end else if (bank == gain_switch_pkg::BANK_BASE && slot_ok) begin
                next_base_set[slot] = wdata;
            end else if (bank == gain_switch_pkg::BANK_ALT && slot_ok) begin
                next_alt_set[slot] = wdata;
            end
        end
        // unmapped addresses and slots read as zero
        if (rd) begin
            if (addr == gain_switch_pkg::REG_SELECT) begin
                next_rdata = gain_switch_select;
            end else if (addr == gain_switch_pkg::REG_THRESHOLD) begin
                next_rdata = switch_droop_threshold;
            end else if (addr == gain_switch_pkg::REG_TC) begin
                next_rdata = switch_time_constant;
            end else if (addr == gain_switch_pkg::REG_STATUS) begin
                next_rdata = DW'(status);
            end else if (bank == gain_switch_pkg::BANK_BASE && slot_ok) begin
                next_rdata = base_set[slot];
            end else if (bank == gain_switch_pkg::BANK_ALT && slot_ok) begin
                next_rdata = alt_set[slot];
            end else if (bank == gain_switch_pkg::BANK_OUT && slot_ok) begin
                next_rdata = param_out[slot];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            gain_switch_select <= gain_switch_pkg::SELECT_RST;
            switch_droop_threshold <= gain_switch_pkg::THRESHOLD_RST;
            switch_time_constant <= gain_switch_pkg::TC_RST;
            base_set <= {NP{gain_switch_pkg::PARAM_RST}};
            alt_set <= {NP{gain_switch_pkg::PARAM_RST}};
            rdata <= '0;
        end else begin
            gain_switch_select <= next_gain_switch_select;
            switch_droop_threshold <= next_switch_droop_threshold;
            switch_time_constant <= next_switch_time_constant;
            base_set <= next_base_set;
            alt_set <= next_alt_set;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // trigger decode and switching state
    // ----------------------------------------------------------------
    gain_switch_pkg::trigger_e trig;
    gain_switch_pkg::tc_option_e tc_opt;
    logic [gain_switch_pkg::DROOP_W-1:0] droop_mag;
    logic active, next_active;

    always_comb begin
        trig = gain_switch_pkg::trigger_e'(gain_switch_select[
            gain_switch_pkg::SEL_TRIG_LSB +: gain_switch_pkg::SEL_FIELD_W]);
        tc_opt = gain_switch_pkg::tc_option_e'(gain_switch_select[
            gain_switch_pkg::SEL_TCOPT_LSB +: gain_switch_pkg::SEL_FIELD_W]);
        droop_mag = droop_pulses[gain_switch_pkg::DROOP_W-1] ?
            gain_switch_pkg::DROOP_W'(-droop_pulses) : droop_pulses;
        unique case (trig)
            gain_switch_pkg::TRIG_CMD: begin
                next_active = ctrl_gain_switch_cmd | gain_switch_input;
            end
            gain_switch_pkg::TRIG_DROOP: begin
                next_active = droop_mag > gain_switch_pkg::DROOP_W'(switch_droop_threshold);
            end
            default: begin
                next_active = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // control cycle timing and lag coefficient
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cyc_cnt, next_cyc_cnt;
    logic tick, next_tick;
    logic primed, next_primed;
    logic [AF:0] alpha, next_alpha;
    logic [DIV_W-1:0] den;
    logic [DIV_W-1:0] quo;

    always_comb begin
        next_tick = 1'b0;
        next_cyc_cnt = cyc_cnt + CNT_W'(1);
        if (cyc_cnt == CNT_W'(CYCLE_CLKS - 1)) begin
            next_cyc_cnt = '0;
            next_tick = 1'b1;
        end
        // alpha = T / (tc + T); a zero time constant gives a full step
        den = DIV_W'(switch_time_constant) * DIV_W'(gain_switch_pkg::NS_PER_MS)
            + DIV_W'(CYCLE_NS);
        quo = (DIV_W'(CYCLE_NS) << AF) / den;
        next_alpha = (AF+1)'(quo);
        // the first tick after reset loads targets directly instead of ramping from zero
        next_primed = primed | tick;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cyc_cnt <= '0;
            tick <= 1'b0;
            primed <= 1'b0;
            alpha <= '0;
            active <= 1'b0;
        end else begin
            cyc_cnt <= next_cyc_cnt;
            tick <= next_tick;
            primed <= next_primed;
            alpha <= next_alpha;
            active <= next_active;
        end
    end

    // ----------------------------------------------------------------
    // target selection and lag channels
    // ----------------------------------------------------------------
    gain_switch_pkg::param_vec_t target;
    logic bypass;
    logic next_settling;
    logic settling;

    always_comb begin
        bypass = !primed
            || (active && tc_opt == gain_switch_pkg::TC_NO_SWITCH_LAG)
            || (!active && tc_opt == gain_switch_pkg::TC_NO_RETURN_LAG);
        next_settling = param_out != target;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            settling <= 1'b0;
        end else begin
            settling <= next_settling;
        end
    end

    assign status.settling = settling;
    assign status.active = active;

    for (genvar i = 0; i < NP; i++) begin : g_chan
        // model gain and vibration sets only follow the command trigger
        assign target[i] = (active && (trig != gain_switch_pkg::TRIG_DROOP
            || i < gain_switch_pkg::NUM_CORE)) ? alt_set[i] : base_set[i];

        lag_filter_channel #(
            .WIDTH(DW),
            .FRAC(AF)
        ) u_lag (
            .mclk(mclk),
            .resetn(resetn),
            .tick(tick),
            .bypass(bypass),
            .alpha(alpha),
            .target(target[i]),
            .value(param_out[i])
        );
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_cmd_on;
        @(posedge mclk) disable iff (!resetn)
        (trig == gain_switch_pkg::TRIG_CMD && (ctrl_gain_switch_cmd || gain_switch_input))
            |=> active;
    endproperty
    a_cmd_on: assert property (p_cmd_on) else $error("command did not switch gains");

    property p_cmd_off;
        @(posedge mclk) disable iff (!resetn)
        (trig == gain_switch_pkg::TRIG_CMD && !ctrl_gain_switch_cmd && !gain_switch_input)
            |=> !active;
    endproperty
    a_cmd_off: assert property (p_cmd_off) else $error("gains stayed switched");

    property p_droop_on;
        @(posedge mclk) disable iff (!resetn)
        (trig == gain_switch_pkg::TRIG_DROOP
            && droop_mag > gain_switch_pkg::DROOP_W'(switch_droop_threshold)) |=> active;
    endproperty
    a_droop_on: assert property (p_droop_on) else $error("droop did not switch");

    property p_droop_off;
        @(posedge mclk) disable iff (!resetn)
        (trig == gain_switch_pkg::TRIG_DROOP
            && droop_mag <= gain_switch_pkg::DROOP_W'(switch_droop_threshold)) |=> !active;
    endproperty
    a_droop_off: assert property (p_droop_off) else $error("droop did not return");

    property p_droop_model_base;
        @(posedge mclk) disable iff (!resetn)
        (tick && primed && trig == gain_switch_pkg::TRIG_DROOP && !wr
            && param_out[gain_switch_pkg::IDX_MODEL] == base_set[gain_switch_pkg::IDX_MODEL])
            |=> param_out[gain_switch_pkg::IDX_MODEL] == base_set[gain_switch_pkg::IDX_MODEL];
    endproperty
    a_droop_model_base: assert property (p_droop_model_base) else $error("model gain moved");

    property p_fast_switch;
        @(posedge mclk) disable iff (!resetn)
        (tick && active && tc_opt == gain_switch_pkg::TC_NO_SWITCH_LAG && !wr)
            |=> param_out[gain_switch_pkg::IDX_SPEED] == alt_set[gain_switch_pkg::IDX_SPEED];
    endproperty
    a_fast_switch: assert property (p_fast_switch) else $error("switch was lagged");

    property p_fast_return;
        @(posedge mclk) disable iff (!resetn)
        (tick && !active && tc_opt == gain_switch_pkg::TC_NO_RETURN_LAG && !wr)
            |=> param_out[gain_switch_pkg::IDX_SPEED] == base_set[gain_switch_pkg::IDX_SPEED];
    endproperty
    a_fast_return: assert property (p_fast_return) else $error("return was lagged");

    property p_lag_rise;
        @(posedge mclk) disable iff (!resetn)
        (tick && !bypass && !wr && param_out[gain_switch_pkg::IDX_POSITION]
            < target[gain_switch_pkg::IDX_POSITION])
            |=> param_out[gain_switch_pkg::IDX_POSITION]
                > $past(param_out[gain_switch_pkg::IDX_POSITION])
            && param_out[gain_switch_pkg::IDX_POSITION]
                <= $past(target[gain_switch_pkg::IDX_POSITION]);
    endproperty
    a_lag_rise: assert property (p_lag_rise) else $error("lag step out of range");

    property p_hold_between_ticks;
        @(posedge mclk) disable iff (!resetn)
        !tick |=> $stable(param_out);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("moved off tick");

    c_cmd_switch: cover property (@(posedge mclk) disable iff (!resetn)
        trig == gain_switch_pkg::TRIG_CMD && $rose(active));
    c_droop_return: cover property (@(posedge mclk) disable iff (!resetn)
        trig == gain_switch_pkg::TRIG_DROOP && $fell(active));
    c_lag_step: cover property (@(posedge mclk) disable iff (!resetn)
        tick && !bypass && settling);
    c_fast_switch: cover property (@(posedge mclk) disable iff (!resetn)
        tick && active && tc_opt == gain_switch_pkg::TC_NO_SWITCH_LAG);

endmodule : gain_switch_core

// ===== sim/motion_ctrl_model.sv
// controller-side model that drives the switching command and the droop count
`timescale 1ns/100ps
module motion_ctrl_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic cmd_req,
    input wire logic signed [31:0] droop_req,
    output logic ctrl_gain_switch_cmd,
    output logic signed [31:0] droop_pulses
);
    // ----------------------------------------------------------------
    // launch stage
    // ----------------------------------------------------------------
    logic cmd_d;
    logic signed [31:0] droop_d;

    // slow mode answers one cycle later, as a busy controller would
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cmd_d <= 1'b0;
            droop_d <= '0;
            ctrl_gain_switch_cmd <= 1'b0;
            droop_pulses <= '0;
        end else begin
            cmd_d <= cmd_req;
            droop_d <= droop_req;
            ctrl_gain_switch_cmd <= slow ? cmd_d : cmd_req;
            droop_pulses <= slow ? droop_d : droop_req;
        end
    end
endmodule : motion_ctrl_model

// ===== sim/servo_gain_switching_tb.sv
// self-checking bench for the gain switching logic
`timescale 1ns/100ps
module servo_gain_switching_tb;
    logic mclk;
    logic resetn;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic [15:0] rdata;
    logic cmd_req;
    logic gsw_in;
    logic slow;
    logic signed [31:0] droop_req;
    logic cmd;
    logic signed [31:0] droop;
    gain_switch_pkg::param_vec_t param_out;
    gain_switch_pkg::switch_status_s status;
    int miscompares;
    int checks;
    logic [15:0] rv;

    motion_ctrl_model motion_ctrl_model_inst (.mclk(mclk), .resetn(resetn), .slow(slow),
        .cmd_req(cmd_req), .droop_req(droop_req), .ctrl_gain_switch_cmd(cmd),
        .droop_pulses(droop));

    // short control cycle keeps lag runs to a few thousand clocks
    gain_switch_core #(.CYCLE_CLKS(4)) gain_switch_core_inst (.mclk(mclk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .ctrl_gain_switch_cmd(cmd), .gain_switch_input(gsw_in), .droop_pulses(droop),
        .param_out(param_out), .status(status));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic clks(input int n);
        repeat (n) @(posedge mclk);
    endtask : clks

    task automatic reg_wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        // read data stand only in the cycle after the strobe, so take them mid-cycle
        @(negedge mclk);
        d = rdata;
        @(posedge mclk);
    endtask : reg_rd

    // slot i carries 0x0100+i as base and 0x0A00+i as alternate
    task automatic expect_set(input logic [12:0] alt_mask);
        for (int i = 0; i < 13; i++) begin
            check(param_out[i], (alt_mask[i] ? 16'h0A00 : 16'h0100) + 16'(i));
        end
    endtask : expect_set

    task automatic wait_settled();
        int n;
        n = 0;
        // a trigger change needs three edges to show as settling, so look past them
        clks(6);
        while (status.settling !== 1'b0 && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 4000) begin
            miscompares++;
            conclude();
        end
    endtask : wait_settled

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_registers();
        reg_rd(gain_switch_pkg::REG_SELECT, rv);
        check(rv, 16'h0000);
        reg_rd(gain_switch_pkg::REG_THRESHOLD, rv);
        check(rv, 16'h0032);
        reg_rd(gain_switch_pkg::REG_TC, rv);
        check(rv, 16'h0064);
        reg_wr(gain_switch_pkg::REG_STATUS, 16'hFFFF);
        reg_rd(gain_switch_pkg::REG_STATUS, rv);
        check(rv, 16'h0000);
        reg_rd(6'h3F, rv);
        check(rv, 16'h0000);
        for (int i = 0; i < 13; i++) begin
            reg_wr({gain_switch_pkg::BANK_BASE, 4'(i)}, 16'h0100 + 16'(i));
            reg_wr({gain_switch_pkg::BANK_ALT, 4'(i)}, 16'h0A00 + 16'(i));
        end
        reg_wr(gain_switch_pkg::REG_TC, 16'h0000);
    endtask : t_registers

    task automatic t_command();
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0001);
        clks(12);
        expect_set(13'h0000);
        cmd_req <= 1'b1;
        clks(12);
        expect_set(13'h1FFF);
        reg_rd(gain_switch_pkg::REG_STATUS, rv);
        check(rv, 16'h0001);
        reg_rd({gain_switch_pkg::BANK_OUT, 4'h4}, rv);
        check(rv, 16'h0A04);
        cmd_req <= 1'b0;
        clks(12);
        expect_set(13'h0000);
        slow <= 1'b1;
        gsw_in <= 1'b1;
        clks(12);
        expect_set(13'h1FFF);
        gsw_in <= 1'b0;
        cmd_req <= 1'b1;
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0002);
        clks(12);
        expect_set(13'h0000);
        cmd_req <= 1'b0;
        slow <= 1'b0;
    endtask : t_command

    task automatic t_droop();
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0003);
        droop_req <= 32'sd51;
        clks(12);
        expect_set(13'h000F);
        reg_rd(gain_switch_pkg::REG_STATUS, rv);
        check(rv, 16'h0001);
        droop_req <= -32'sd51;
        clks(12);
        expect_set(13'h000F);
        droop_req <= 32'sd50;
        clks(12);
        expect_set(13'h0000);
        droop_req <= 32'sd0;
        cmd_req <= 1'b1;
        clks(12);
        expect_set(13'h0000);
        cmd_req <= 1'b0;
    endtask : t_droop

    task automatic t_lag();
        reg_wr(gain_switch_pkg::REG_TC, 16'h0001);
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0001);
        cmd_req <= 1'b1;
        // one time constant of 1 ms is 50 control cycles of 4 clocks
        clks(201);
        check(16'(param_out[0] > 16'h0670 && param_out[0] < 16'h06FA), 16'h0001);
        wait_settled();
        check(param_out[0], 16'h0A00);
        cmd_req <= 1'b0;
        wait_settled();
        check(param_out[0], 16'h0100);
    endtask : t_lag

    task automatic t_lag_options();
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0103);
        droop_req <= 32'sd100;
        clks(12);
        check(param_out[0], 16'h0A00);
        droop_req <= 32'sd0;
        clks(12);
        check(16'(param_out[0] > 16'h0900), 16'h0001);
        wait_settled();
        reg_wr(gain_switch_pkg::REG_SELECT, 16'h0201);
        cmd_req <= 1'b1;
        clks(12);
        check(16'(param_out[0] < 16'h0200), 16'h0001);
        wait_settled();
        cmd_req <= 1'b0;
        clks(12);
        check(param_out[0], 16'h0100);
    endtask : t_lag_options

    initial begin
        miscompares = 0;
        checks = 0;
        resetn = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        cmd_req = 1'b0;
        gsw_in = 1'b0;
        slow = 1'b0;
        droop_req = '0;
        clks(5);
        resetn <= 1'b1;
        t_registers();
        t_command();
        t_droop();
        t_lag();
        t_lag_options();
        conclude();
    end
endmodule : servo_gain_switching_tb
